// file: design/adc_seq_pkg.sv
// shared constants and types of the conversion sequencer
package adc_seq_pkg;
   // register byte offsets on the apb slave
   localparam logic [7:0] CSR_OFS = 8'h00;
   localparam logic [7:0] TCR_OFS = 8'h04;
   localparam logic [7:0] DMA_OFS = 8'h08;
   localparam logic [7:0] RES_BASE = 8'h20;
   // control_status_reg field positions
   localparam int FLAG_BIT = 7;
   localparam int IE_BIT = 6;
   localparam int GO_BIT = 5;
   localparam int SCAN_BIT = 4;
   localparam int CKS_BIT = 3;
   localparam int GRP_BIT = 2;
   // trigger_control_reg field positions
   localparam int TRIGGER_ENABLE_BIT = 7;
   localparam int TCR_SPARE_BIT = 0;
   // reset values, and the trigger_control_reg bits that always read as one
   localparam logic [7:0] CSR_RST = 8'h00;
   localparam logic [7:0] TCR_RST = 8'h7e;
   localparam logic [7:0] TCR_ONES = 8'h7e;
   // converter geometry
   localparam int RES_BITS = 10;
   localparam int CH_NUM = 8;
   // times in states; one state is one pclk cycle
   localparam int STATE_CYCLES = 1;
   localparam int TD_SLOW_ST = 6;
   localparam int TD_FAST_ST = 4;
   localparam int SPL_SLOW_ST = 31;
   localparam int SPL_FAST_ST = 15;
   localparam int BODY_SLOW_ST = 94;
   localparam int BODY_FAST_ST = 50;
   localparam int GAP_SLOW_ST = 3;
   localparam int GAP_FAST_ST = 1;
   localparam int STEP_SLOW_ST = 9;
   localparam int STEP_FAST_ST = 4;
   // derived cycle counts, loaded as count minus one
   localparam logic [7:0] TD_SLOW_C = 8'(TD_SLOW_ST * STATE_CYCLES - 1);
   localparam logic [7:0] TD_FAST_C = 8'(TD_FAST_ST * STATE_CYCLES - 1);
   localparam logic [7:0] SPL_SLOW_C = 8'(SPL_SLOW_ST * STATE_CYCLES - 1);
   localparam logic [7:0] SPL_FAST_C = 8'(SPL_FAST_ST * STATE_CYCLES - 1);
   localparam logic [7:0] BODY_SLOW_C = 8'(BODY_SLOW_ST * STATE_CYCLES - 1);
   localparam logic [7:0] BODY_FAST_C = 8'(BODY_FAST_ST * STATE_CYCLES - 1);
   localparam logic [7:0] GAP_SLOW_C = 8'(GAP_SLOW_ST * STATE_CYCLES - 1);
   localparam logic [7:0] GAP_FAST_C = 8'(GAP_FAST_ST * STATE_CYCLES - 1);
   localparam logic [3:0] STEP_SLOW_C = 4'(STEP_SLOW_ST * STATE_CYCLES - 1);
   localparam logic [3:0] STEP_FAST_C = 4'(STEP_FAST_ST * STATE_CYCLES - 1);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SYNC,
      ST_SAMPLE,
      ST_CONVERT,
      ST_GAP
   } seq_state_t;
endpackage

// file: design/sar_register.sv
// successive-approximation register stepping one bit per period
`timescale 1ns/10ps
`default_nettype none
module sar_register
   import adc_seq_pkg::*;
#(
   parameter int RES_W = RES_BITS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic fast,
   input wire logic comp_hi,
   output logic [RES_W-1:0] code_q
);
   logic [RES_W-1:0] bit_q;
   logic [3:0] step_q;
   logic [RES_W-1:0] top_bit;
   logic [RES_W-1:0] keep;
   logic [3:0] period;
   logic step_now;

   assign top_bit = {1'b1, {(RES_W-1){1'b0}}};
   assign period = fast ? STEP_FAST_C : STEP_SLOW_C;
   assign step_now = (bit_q != '0) && (step_q == 4'h0);
   // comparator says input above trial code: the trial bit stays
   assign keep = comp_hi ? bit_q : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q <= '0;
         bit_q <= '0;
         step_q <= 4'h0;
      end else if (start) begin
         code_q <= top_bit;
         bit_q <= top_bit;
         step_q <= period;
      end else if (step_now) begin
         code_q <= (code_q & ~bit_q) | keep | (bit_q >> 1);
         bit_q <= bit_q >> 1;
         step_q <= period;
      end else if (bit_q != '0) begin
         step_q <= step_q - 4'h1;
      end
   end
endmodule
`default_nettype wire

// file: design/adc_conversion_sequencer.sv
// eight-input sar converter sequencer with apb register file
// Operation
// - single mode: go stays set, clears after
// - single finish: store, flag, clear go, idle
// - flag set with enable raises request immediately
// - flag clears by read then write zero, or by dma transfer
// - go with new mode/channel in one write
// - scan starts on group first channel
// - scan continues channel to channel until stopped
// - result lands in converted channel's register
// - scan flag after whole group, restart first
// - restart after stop begins at group start
// - sampling follows synchronisation delay after start
// - first conversion 131 slow, 69 fast states
// - later scan conversions 128 or 66 states
// - enabled external falling edge sets go
// - triggered start behaves like software start
// - dma-designated request bypasses the processor
// - dma transfer clears the end flag
// - each conversion gives ten-bit result
// - speed select picks 134 or 70 states; code gives 131 or 69, then 128 or 66 in scan
// - group bit plus low bits select channels
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer
   import adc_seq_pkg::*;
#(
   parameter int RES_W = RES_BITS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic standby,
   input wire logic ext_trigger_pin,
   input wire logic timer_trigger_select,
   input wire logic timer_match,
   input wire logic comp_hi,
   input wire logic dma_ack,
   output logic [2:0] chan_sel,
   output logic sample_hold,
   output logic [RES_W-1:0] dac_code,
   output logic conversion_end_irq,
   output logic dma_req
);
   if (RES_W < 1 || RES_W > 16) begin : g_bad_width
      $error("result width must be 1 to 16");
   end

   seq_state_t state_q, state_d;
   logic [7:0] csr_q, csr_d;
   logic [7:0] tcr_q, tcr_d;
   logic dma_sel_q;
   logic armed_q, armed_d;
   logic [7:0] cnt_q, cnt_d;
   logic [2:0] chan_q, chan_d;
   logic [RES_W-1:0] res_q [CH_NUM];
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic irq_q, dma_q, sample_q;
   logic trg_s1_q, trg_s2_q, trg_s3_q;
   logic comp_s1_q, comp_s2_q;
   logic [RES_W-1:0] sar_code;

   // apb decode
   wire setup = psel && !penable;
   wire access = psel && penable && pready_q;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire csr_sel = (paddr == CSR_OFS);
   wire tcr_sel = (paddr == TCR_OFS);
   wire dma_sel = (paddr == DMA_OFS);
   wire res_sel = (paddr[7:5] == RES_BASE[7:5]) && (paddr[1:0] == 2'h0);
   wire [2:0] res_idx = paddr[4:2];
   wire mapped = csr_sel || tcr_sel || dma_sel || res_sel;
   wire csr_wr = wr && csr_sel;
   wire tcr_wr = wr && tcr_sel;
   wire dma_wr = wr && dma_sel;
   wire [31:0] res_word = {{(32-RES_W){1'b0}}, res_q[res_idx]};
   wire [31:0] rd_mux = csr_sel ? {24'h0, csr_q} :
                        tcr_sel ? {24'h0, tcr_q | TCR_ONES} :
                        dma_sel ? {31'h0, dma_sel_q} :
                        res_sel ? res_word : 32'h0;

   // control fields
   wire scan_q = csr_q[SCAN_BIT];
   wire fast_q = csr_q[CKS_BIT];
   wire go_q = csr_q[GO_BIT];
   wire flag_q = csr_q[FLAG_BIT];
   wire ie_new = csr_d[IE_BIT];
   wire trigger_enable_q = tcr_q[TRIGGER_ENABLE_BIT];

   // start sources
   wire trg_fall = trg_s3_q && !trg_s2_q;
   wire ext_start = trigger_enable_q && !timer_trigger_select && trg_fall;
   wire tmr_start = trigger_enable_q && timer_trigger_select && timer_match;
   wire trig_start = ext_start || tmr_start;

   // sequencing terms
   wire cnt_zero = (cnt_q == 8'h00);
   wire done = (state_q == ST_CONVERT) && cnt_zero;
   wire last_ch = (chan_q[1:0] == csr_q[1:0]);
   wire [2:0] group_first = {csr_q[GRP_BIT], 2'b00};
   // a stop written at the finishing edge wins: no store, no flag
   wire sw_stop = csr_wr && !pwdata[GO_BIT];
   wire keep_run = !sw_stop && !standby;
   wire group_end = done && (!scan_q || last_ch) && keep_run;
   wire single_done = done && !scan_q;

   // go bit: software write, trigger set, single completion clear
   logic go_d;
   always_comb begin
      go_d = go_q;
      if (csr_wr) begin
         go_d = pwdata[GO_BIT];
      end
      if (single_done && !trig_start) begin
         go_d = 1'b0;
      end
      if (trig_start) begin
         go_d = 1'b1;
      end
   end

   wire start = go_d && (!go_q || single_done);
   // mode and channel as they stand after this edge's write
   wire [7:0] ctl_new = csr_wr ? pwdata[7:0] : csr_q;
   wire [2:0] start_ch = ctl_new[SCAN_BIT] ? {ctl_new[GRP_BIT], 2'b00}
                                          : ctl_new[2:0];
   wire fast_new = ctl_new[CKS_BIT];

   // flag: set beats clear; software clear needs a prior read, dma_ack clear does not
   wire flag_clr_sw = csr_wr && !pwdata[FLAG_BIT] && armed_q;
   wire flag_clr = flag_clr_sw || dma_ack;
   wire flag_d = group_end || (flag_q && !flag_clr);

   always_comb begin
      csr_d = csr_q;
      if (csr_wr) begin
         csr_d[IE_BIT:0] = pwdata[IE_BIT:0];
      end
      csr_d[GO_BIT] = go_d;
      csr_d[FLAG_BIT] = flag_d;
   end

   always_comb begin
      tcr_d = tcr_q;
      if (tcr_wr) begin
         tcr_d[TRIGGER_ENABLE_BIT] = pwdata[TRIGGER_ENABLE_BIT];
         tcr_d[TCR_SPARE_BIT] = pwdata[TCR_SPARE_BIT];
      end
   end

   always_comb begin
      armed_d = armed_q;
      if (rd && csr_sel && flag_q) begin
         armed_d = 1'b1;
      end else if (csr_wr || !flag_q) begin
         armed_d = 1'b0;
      end
   end

   // sequencer
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      chan_d = chan_q;
      if (!cnt_zero) begin
         cnt_d = cnt_q - 8'h01;
      end
      if (!go_d) begin
         state_d = ST_IDLE;
         cnt_d = 8'h00;
      end else if (start) begin
         state_d = ST_SYNC;
         chan_d = start_ch;
         cnt_d = fast_new ? TD_FAST_C : TD_SLOW_C;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               state_d = ST_IDLE;
            end
            ST_SYNC: begin
               if (cnt_zero) begin
                  state_d = ST_SAMPLE;
                  cnt_d = fast_q ? SPL_FAST_C : SPL_SLOW_C;
               end
            end
            ST_SAMPLE: begin
               if (cnt_zero) begin
                  state_d = ST_CONVERT;
                  cnt_d = fast_q ? BODY_FAST_C : BODY_SLOW_C;
               end
            end
            ST_CONVERT: begin
               if (cnt_zero) begin
                  // scan mode: next channel, wrap to group start
                  state_d = ST_GAP;
                  chan_d = last_ch ? group_first : chan_q + 3'h1;
                  cnt_d = fast_q ? GAP_FAST_C : GAP_SLOW_C;
               end
            end
            ST_GAP: begin
               if (cnt_zero) begin
                  state_d = ST_SAMPLE;
                  cnt_d = fast_q ? SPL_FAST_C : SPL_SLOW_C;
               end
            end
         endcase
      end
   end

   wire sar_start = (state_q == ST_SAMPLE) && cnt_zero && go_d && !start;
   // next-state terms, so the requests follow the registers exactly
   wire dma_sel_d = dma_wr ? pwdata[0] : dma_sel_q;
   wire irq_d = flag_d && ie_new;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trg_s1_q <= 1'b1;
         trg_s2_q <= 1'b1;
         trg_s3_q <= 1'b1;
         comp_s1_q <= 1'b0;
         comp_s2_q <= 1'b0;
      end else begin
         trg_s1_q <= ext_trigger_pin;
         trg_s2_q <= trg_s1_q;
         trg_s3_q <= trg_s2_q;
         comp_s1_q <= comp_hi;
         comp_s2_q <= comp_s1_q;
      end
   end

   // standby initialises like reset but synchronously, except dma select and channel, which keep their values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csr_q <= CSR_RST;
         tcr_q <= TCR_RST;
         dma_sel_q <= 1'b0;
         armed_q <= 1'b0;
         state_q <= ST_IDLE;
         cnt_q <= 8'h00;
         chan_q <= 3'h0;
      end else if (standby) begin
         csr_q <= CSR_RST;
         tcr_q <= TCR_RST;
         armed_q <= 1'b0;
         state_q <= ST_IDLE;
         cnt_q <= 8'h00;
      end else begin
         csr_q <= csr_d;
         tcr_q <= tcr_d;
         dma_sel_q <= dma_sel_d;
         armed_q <= armed_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         chan_q <= chan_d;
      end
   end

   // request steering; the flag drives it so it drops with the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
         dma_q <= 1'b0;
         sample_q <= 1'b0;
      end else begin
         irq_q <= irq_d && !dma_sel_d && !standby;
         dma_q <= irq_d && dma_sel_d && !standby;
         sample_q <= go_d && !start && !standby &&
                     (state_d == ST_SAMPLE);
      end
   end

   // one result register per channel
   for (genvar i = 0; i < CH_NUM; i++) begin : g_res
      wire hit = done && keep_run && (chan_q == 3'(i));
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            res_q[i] <= '0;
         end else if (hit) begin
            res_q[i] <= sar_code;
         end
      end
   end

   // single-cycle access phase: data prepared during setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= (setup && !pwrite) ? rd_mux : prdata_q;
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
      end
   end

   sar_register #(
      .RES_W(RES_W)
   ) u_sar (
      .pclk(pclk),
      .presetn(presetn),
      .start(sar_start),
      .fast(fast_q),
      .comp_hi(comp_s2_q),
      .code_q(sar_code)
   );

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign chan_sel = chan_q;
   assign sample_hold = sample_q;
   assign dac_code = sar_code;
   assign conversion_end_irq = irq_q;
   assign dma_req = dma_q;
endmodule
`default_nettype wire

// file: dv/analog_src.sv
// analog input sources and comparator in front of the sequencer
`timescale 1ns/10ps
`default_nettype none
module analog_src (
   input wire logic [2:0] chan_sel,
   input wire logic [9:0] dac_code,
   input wire logic [9:0] vin [8],
   output logic comp_hi
);
   // inputs sit half a code above vin, so a trial never ties
   assign comp_hi = {vin[chan_sel], 1'b1} > {dac_code, 1'b0};
endmodule
`default_nettype wire

// file: dv/adc_seq_asserts.sv
// port-level checks of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_seq_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic standby,
   input wire logic dma_ack,
   input wire logic [2:0] chan_sel,
   input wire logic sample_hold,
   input wire logic conversion_end_irq,
   input wire logic dma_req
);
   logic [7:0] hold_q;
   logic [7:0] hold_d;
   assign hold_d = sample_hold ? hold_q + 8'h01 : 8'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hold_q <= 8'h00;
      else
         hold_q <= hold_d;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_sampling;
      sample_hold [*2];
   endsequence
   a_ready_setup: assert property (s_setup |=> pready)
      else $error("no pready after setup");
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_access: assert property (pslverr |-> pready)
      else $error("pslverr outside access");
   a_irq_dma_split: assert property (
      !(conversion_end_irq && dma_req))
      else $error("irq and dma request together");
   // a write or standby may cut sampling short, so those are left out
   a_sample_len: assert property (
      $fell(sample_hold) && !$past(psel) && !$past(psel, 2) &&
      !$past(standby) |-> hold_q inside {8'h1f, 8'h0f})
      else $error("sampling length wrong");
   a_sample_gap: assert property (
      $fell(sample_hold) |-> !sample_hold [*5])
      else $error("sampling restarted too soon");
   a_chan_steady: assert property (
      s_sampling |-> $stable(chan_sel))
      else $error("channel moved while sampling");
   a_irq_stands: assert property (conversion_end_irq &&
      !(psel && pwrite) && !standby && !dma_ack |=> conversion_end_irq)
      else $error("irq dropped without clear");
   a_dma_stands: assert property (dma_req &&
      !(psel && pwrite) && !standby && !dma_ack |=> dma_req)
      else $error("dma request dropped without ack");
   a_ack_clears: assert property (dma_ack && dma_req |=> !dma_req)
      else $error("dma ack left request up");
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import adc_seq_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_q;
   logic pready, pslverr, err_q, comp_hi, sample_hold, irq, dma_req;
   logic standby = 1'b0, ext_trigger_pin = 1'b1, dma_ack = 1'b0;
   logic timer_trigger_select = 1'b0, timer_match = 1'b0;
   logic [2:0] chan_sel;
   logic [9:0] dac_code;
   logic [9:0] vin [8];
   wire logic [2:0] evt = {dma_req, sample_hold, irq};
   int n_mismatch = 0, samples_checked = 0, n;
   always #4 pclk = ~pclk;
   adc_conversion_sequencer adc_conversion_sequencer_inst (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .standby, .ext_trigger_pin, .timer_trigger_select,
      .timer_match, .comp_hi, .dma_ack, .chan_sel, .sample_hold, .dac_code,
      .conversion_end_irq(irq), .dma_req);
   analog_src analog_src_inst (.chan_sel, .dac_code, .vin, .comp_hi);
   function automatic logic [9:0] v(input int i);
      return 10'h013 + 10'(i) * 10'h041;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // starts one edge late so a release and a new setup never share a step
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd_q, exp);
   endtask
   task automatic wait_for(input int w);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (evt[w] !== 1'b1);
   endtask
   task print_verdict;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      for (int i = 0; i < 8; i++)
         vin[i] = v(i);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(CSR_OFS, 32'h00);
      rd(TCR_OFS, 32'h7e);
      rd(RES_BASE, 32'h0);
      rd(8'h40, 32'h0);
      chk(err_q, 1'b1);
      wr(TCR_OFS, 32'h81);
      rd(TCR_OFS, 32'hff);
      wr(CSR_OFS, 32'h61);
      wait_for(0);
      // 131 states, seen one edge later
      chk(n, 32'h84);
      chk(dac_code, v(1));
      wr(CSR_OFS, 32'h41);
      @(negedge pclk);
      chk(irq, 1'b1);
      rd(CSR_OFS, 32'hc1);
      rd(RES_BASE + 8'h04, v(1));
      wr(CSR_OFS, 32'h41);
      @(negedge pclk);
      chk(irq, 1'b0);
      rd(CSR_OFS, 32'h41);
      wr(CSR_OFS, 32'h7d);
      wait_for(0);
      chk(n, 32'h88);
      // stop lands while channel 5 samples its changed input
      vin[5] <= 10'h3e0;
      repeat (70) @(posedge pclk);
      wr(CSR_OFS, 32'h5d);
      rd(RES_BASE + 8'h10, v(4));
      rd(RES_BASE + 8'h14, v(5));
      rd(CSR_OFS, 32'hdd);
      wr(CSR_OFS, 32'h5d);
      wr(CSR_OFS, 32'h7d);
      wait_for(1);
      chk(chan_sel, 32'h4);
      wr(CSR_OFS, 32'h5d);
      wr(TCR_OFS, 32'h80);
      rd(TCR_OFS, 32'hfe);
      wr(CSR_OFS, 32'h47);
      ext_trigger_pin <= 1'b0;
      wait_for(0);
      chk(n > 132 && n < 140, 1'b1);
      rd(RES_BASE + 8'h1c, v(7));
      rd(CSR_OFS, 32'hc7);
      wr(CSR_OFS, 32'h47);
      ext_trigger_pin <= 1'b1;
      wr(DMA_OFS, 32'h1);
      timer_trigger_select <= 1'b1;
      wr(CSR_OFS, 32'h4a);
      timer_match <= 1'b1;
      @(posedge pclk);
      timer_match <= 1'b0;
      wait_for(2);
      chk(irq, 1'b0);
      rd(RES_BASE + 8'h08, v(2));
      dma_ack <= 1'b1;
      @(posedge pclk);
      dma_ack <= 1'b0;
      @(negedge pclk);
      chk(dma_req, 1'b0);
      rd(CSR_OFS, 32'h4a);
      standby <= 1'b1;
      @(posedge pclk);
      standby <= 1'b0;
      rd(CSR_OFS, 32'h00);
      rd(TCR_OFS, 32'h7e);
      rd(RES_BASE + 8'h08, v(2));
      print_verdict();
   end
endmodule
bind adc_conversion_sequencer adc_seq_asserts adc_seq_asserts_inst (
   .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .standby,
   .dma_ack, .chan_sel, .sample_hold, .conversion_end_irq, .dma_req);
`default_nettype wire
